/* inc/pao_pkg.sv */
// constants for the pipelined converter output interface
// assumes one 10 MHz clock and an asynchronous active-high reset
//
// Contract
// - a new sample is taken at each falling clock edge, the switch opening shortly after.
// - the code of a sample reaches the pins two cycles after it was taken, plus output delay.
// - one fresh word is produced every running cycle and the capture side reads one per clock unless it stalls.
// - conversion runs while the clock runs and sleep_request is low, and stops otherwise.
// - with the active-low output enable low and sleep_request low, the pins are driven with the current result.
// - with output enable high or sleep_request high, the data_o pins are released; the stream outputs stay driven.
// - the input span between the two reference levels is quantised to ten bits.
// - inputs below the lower level give all zeros, inputs above the upper give all ones.
// - codes run from 0 to 1023, the top transition going from 1022 to 1023.
// - each data_o update appears a fixed delay after the falling clock edge; the stream outputs change on the rising edge.
// - the previous word stays valid on the pins for the hold time after the falling edge.
package pao_pkg;
	localparam int DATA_W = 10;
	localparam int SAMPLE_W = 12;
	localparam logic [DATA_W-1:0] CODE_MIN = 10'h000;
	localparam logic [DATA_W-1:0] CODE_MAX = 10'h3FF;
	localparam int PIPE_DEPTH = 2;
	localparam int FIFO_DEPTH = 16;
	localparam int CLK_PERIOD_NS = 100;
	localparam int WAKE_NS = 700;
	localparam int WAKE_CYC = (WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] WAKE_CYC_W = 4'(WAKE_CYC);
	localparam logic [3:0] ZERO_CNT = 4'h0;
endpackage

/* rtl/pao_fifo.sv */
// synchronous fifo with valid/ready on both sides
// assumes one clock and an asynchronous active-high reset
`timescale 1ns/1ps
module pao_fifo
	import pao_pkg::*;
#(
	parameter int WIDTH = 10,
	parameter int DEPTH = 16
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW:0] wr;
		logic [AW:0] rd;
	} pao_fifo_st_t;
	pao_fifo_st_t s_q, s_d;
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic full, empty, push, pop;

	assign full = (s_q.wr[AW] != s_q.rd[AW]) && (s_q.wr[AW-1:0] == s_q.rd[AW-1:0]);
	assign empty = s_q.wr == s_q.rd;
	assign in_ready_o = !full;
	assign out_valid_o = !empty;
	assign push = in_valid_i && !full;
	assign pop = out_ready_i && !empty;
	assign out_data_o = mem_q[s_q.rd[AW-1:0]];

	always_comb begin
		s_d = s_q;
		if (push) begin
			s_d.wr = s_q.wr + (AW + 1)'(1);
		end
		if (pop) begin
			s_d.rd = s_q.rd + (AW + 1)'(1);
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_q[s_q.wr[AW-1:0]] <= in_data_i;
		end
	end
endmodule

/* rtl/pao_top.sv */
// output side of a pipelined ten-bit converter
// assumes sample_i comes from a digital quantiser model on the same clock
`timescale 1ns/1ps
module pao_top
	import pao_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [SAMPLE_W-1:0] sample_i,
	input wire logic [SAMPLE_W-1:0] ref_low_i,
	input wire logic [SAMPLE_W-1:0] ref_high_i,
	input wire logic sleep_request_i,
	input wire logic out_enable_n_i,
	output logic [DATA_W-1:0] data_o,
	output logic data_oe_o,
	output logic data_valid_o,
	output logic settled_o,
	output logic [DATA_W-1:0] stream_data_o,
	output logic stream_valid_o,
	input wire logic stream_ready_i,
	output logic overflow_o
);
	typedef struct packed {
		logic [1:0] sleep_sync;
		logic [1:0] oen_sync;
		logic [PIPE_DEPTH-1:0][DATA_W-1:0] pipe;
		logic [PIPE_DEPTH-1:0] pvld;
		logic [DATA_W-1:0] out;
		logic outv;
		logic [3:0] wake;
		logic ovf;
	} pao_st_t;
	pao_st_t s_q, s_d;
	logic fifo_ready;

	// clamp and scale a sample into a ten-bit code
	function automatic logic [DATA_W-1:0] quantise(input logic [SAMPLE_W-1:0] v,
		input logic [SAMPLE_W-1:0] lo, input logic [SAMPLE_W-1:0] hi);
		logic [SAMPLE_W-1:0] span;
		logic [SAMPLE_W+DATA_W-1:0] prod;
		logic [SAMPLE_W+DATA_W-1:0] q;
		span = hi - lo;
		prod = '0;
		q = '0;
		if (v <= lo || hi <= lo) begin
			quantise = CODE_MIN;
		end else if (v >= hi) begin
			quantise = CODE_MAX;
		end else begin
			prod = (SAMPLE_W + DATA_W)'(v - lo) * (SAMPLE_W + DATA_W)'(CODE_MAX);
			q = prod / (SAMPLE_W + DATA_W)'(span);
			quantise = (q > (SAMPLE_W + DATA_W)'(CODE_MAX)) ? CODE_MAX : q[DATA_W-1:0];
		end
	endfunction

	logic running;
	assign running = !s_q.sleep_sync[1];

	always_comb begin
		s_d = s_q;
		s_d.sleep_sync = {s_q.sleep_sync[0], sleep_request_i};
		s_d.oen_sync = {s_q.oen_sync[0], out_enable_n_i};
		if (running) begin
			s_d.pipe[0] = quantise(sample_i, ref_low_i, ref_high_i);
			s_d.pvld[0] = 1'b1;
			s_d.pipe[1] = s_q.pipe[0];
			s_d.pvld[1] = s_q.pvld[0];
			s_d.out = s_q.pipe[1];
			s_d.outv = s_q.pvld[1];
			if (s_q.wake != ZERO_CNT) begin
				s_d.wake = s_q.wake - 4'h1;
			end
		end else begin
			s_d.pvld = '0;
			s_d.outv = 1'b0;
			s_d.wake = WAKE_CYC_W;
		end
		if (s_d.outv && !fifo_ready) begin
			s_d.ovf = 1'b1;
		end
	end

	// pipeline advances on the falling edge; pins change after it and hold until the next
	always_ff @(negedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign data_o = s_q.out;
	assign data_oe_o = !s_q.oen_sync[1] && running;
	assign data_valid_o = s_q.outv && data_oe_o;
	assign settled_o = s_q.wake == ZERO_CNT && s_q.outv;
	assign overflow_o = s_q.ovf;

	pao_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.in_valid_i(s_q.outv),
		.in_ready_o(fifo_ready),
		.in_data_i(s_q.out),
		.out_valid_o(stream_valid_o),
		.out_ready_i(stream_ready_i),
		.out_data_o(stream_data_o)
	);
endmodule

/* dv/pao_props.sv */
// checker for the converter output pins and stream
// assumes the ports of pao_top, refs held steady
`timescale 1ns/1ps
module pao_props
	import pao_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [SAMPLE_W-1:0] sample_i,
	input wire logic [SAMPLE_W-1:0] ref_low_i,
	input wire logic [SAMPLE_W-1:0] ref_high_i,
	input wire logic sleep_request_i,
	input wire logic out_enable_n_i,
	input wire logic [DATA_W-1:0] data_o,
	input wire logic data_oe_o,
	input wire logic data_valid_o,
	input wire logic settled_o,
	input wire logic [DATA_W-1:0] stream_data_o,
	input wire logic stream_valid_o,
	input wire logic stream_ready_i,
	input wire logic overflow_o
);
	default clocking @(negedge clk_i); endclocking
	default disable iff (rst_i);
	AST_OE_OFF: assert property (out_enable_n_i[*4] |-> !data_oe_o) else $error("oe off");
	AST_SLEEP: assert property (sleep_request_i[*4] |-> !data_oe_o && !data_valid_o)
		else $error("sleep");
	AST_DRIVE: assert property ((!out_enable_n_i && !sleep_request_i)[*3] |-> data_oe_o)
		else $error("drive");
	AST_LOW: assert property (data_valid_o && $past(sample_i, 3) <= ref_low_i
		&& $past(sample_i, 4) <= ref_low_i |-> data_o == CODE_MIN) else $error("low");
	AST_HIGH: assert property (data_valid_o && $past(sample_i, 3) >= ref_high_i
		&& $past(sample_i, 4) >= ref_high_i |-> data_o == CODE_MAX) else $error("high");
	AST_SETTLE: assert property (sleep_request_i[*3] ##1 !sleep_request_i
		|-> (!settled_o)[*8]) else $error("settle");
	AST_LIVE: assert property ((!sleep_request_i && !out_enable_n_i)[*8] |-> data_valid_o)
		else $error("live");
	AST_OVF: assert property ($past(overflow_o) |-> overflow_o) else $error("ovf");
	AST_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
		stream_valid_o && !stream_ready_i |=> stream_valid_o && $stable(stream_data_o))
		else $error("hold");
	cover property (overflow_o);
	cover property (settled_o);
	cover property (data_valid_o && data_o == CODE_MAX);
endmodule
bind pao_top pao_props i_props (.clk_i, .rst_i, .sample_i, .ref_low_i, .ref_high_i,
	.sleep_request_i, .out_enable_n_i, .data_o, .data_oe_o, .data_valid_o, .settled_o,
	.stream_data_o, .stream_valid_o, .stream_ready_i, .overflow_o);

/* dv/pao_capture.sv */
// capture side model: takes stream words, may stall
// assumes one clock shared with the converter
`timescale 1ns/1ps
module pao_capture
	import pao_pkg::*;
(
	input wire logic clk_i,
	input wire logic stall_i,
	input wire logic sleep_i,
	input wire logic stream_valid_i,
	output logic stream_ready_o = 1'b0,
	output int n_words_o = 0
);
	logic sleep_q = 1'b0;
	int skip_cnt = 0;
	always @(posedge clk_i) begin
		stream_ready_o <= #10 !stall_i;
		sleep_q <= sleep_i;
		if (stream_valid_i && stream_ready_o && skip_cnt == 0) begin
			n_words_o <= n_words_o + 1;
		end
		if (sleep_q && !sleep_i) begin
			skip_cnt <= PIPE_DEPTH;
		end else if (stream_valid_i && stream_ready_o && skip_cnt > 0) begin
			skip_cnt <= skip_cnt - 1;
		end
	end
endmodule

/* dv/pao_top_tb.sv */
// testbench for pao_top
// assumes the capture model and checker beside it
`timescale 1ns/1ps
module pao_top_tb;
	import pao_pkg::*;
	logic clk_i = 0, rst_i = 1, slp = 0, oe_n = 0, stall = 0, rdy, oe, vld, stl, sv, ovf;
	logic [SAMPLE_W-1:0] smp = 12'h000;
	logic [DATA_W-1:0] d, sd;
	int n_mismatch = 0, samples_checked = 0, nw;
	initial forever #50 clk_i = ~clk_i;
	pao_top i_dut (.clk_i, .rst_i, .sample_i(smp), .ref_low_i(12'h100), .ref_high_i(12'h500),
		.sleep_request_i(slp), .out_enable_n_i(oe_n), .data_o(d), .data_oe_o(oe),
		.data_valid_o(vld), .settled_o(stl), .stream_data_o(sd), .stream_valid_o(sv),
		.stream_ready_i(rdy), .overflow_o(ovf));
	pao_capture i_cap (.clk_i, .stall_i(stall), .sleep_i(slp), .stream_valid_i(sv),
		.stream_ready_o(rdy),
		.n_words_o(nw));
	task automatic chk(input logic [DATA_W-1:0] s, input logic [DATA_W-1:0] e);
		samples_checked++;
		if (s !== e) begin
			n_mismatch++;
			$display("unexpected %0t got %h want %h", $time, s, e);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#10;
	endtask
	task automatic t_code(input logic [SAMPLE_W-1:0] v, input logic [DATA_W-1:0] e);
		smp = v;
		cyc(8);
		chk(d, e);
		chk(oe, 1'b1);
		chk(vld, 1'b1);
	endtask
	task automatic t_lat;
		smp = 12'h050;
		cyc(2);
		chk(d, CODE_MAX);
		#50;
		chk(d, CODE_MIN);
		cyc(1);
		chk(d, CODE_MIN);
	endtask
	task automatic t_float;
		oe_n = 1;
		cyc(4);
		chk(oe, 1'b0);
		oe_n = 0;
		slp = 1;
		cyc(4);
		chk(oe, 1'b0);
		chk(vld, 1'b0);
		slp = 0;
		cyc(14);
		chk(stl, 1'b1);
	endtask
	task automatic t_fifo;
		int n0;
		smp = 12'h300;
		cyc(8);
		chk(ovf, 1'b0);
		stall = 1;
		cyc(24);
		chk(ovf, 1'b1);
		chk(sv, 1'b1);
		chk(sd, 10'h1ff);
		n0 = nw;
		slp = 1;
		stall = 0;
		cyc(24);
		chk(sv, 1'b0);
		chk(10'(nw - n0), 10'(FIFO_DEPTH));
		slp = 0;
		cyc(14);
	endtask
	task close_out;
		if (n_mismatch == 0 && samples_checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		cyc(16);
		rst_i = 0;
		t_code(12'h050, CODE_MIN);
		t_code(12'h700, CODE_MAX);
		t_code(12'h300, 10'h1ff);
		t_code(12'h4ff, 10'h3fe);
		t_code(12'h500, CODE_MAX);
		t_lat;
		t_float;
		t_fifo;
		close_out;
	end
	initial begin
		#500000;
		n_mismatch++;
		close_out;
	end
endmodule
